// file: logic/swp_defs.svh
// Constants shared by both ends of the write-protect command link.
`ifndef SWP_DEFS_SVH
`define SWP_DEFS_SVH
`define SWP_OP_WREN 8'h06
`define SWP_OP_WRDI 8'h04
`define SWP_OP_PROT 8'h36
`define SWP_OP_UNPROT 8'h39
`define SWP_ADDR_BYTES 3
`define SWP_SECTORS 8
`define SWP_SECTOR_LSB 16
`define SWP_PROT_RST 1'b1
`define SWP_WEL_RST 1'b0
`define SWP_SCK_HALF 4
`endif

// file: logic/swp_pkg.sv
// Types shared by both ends of the write-protect command link.
package swp_pkg;
  typedef enum logic [1:0] {
    SWP_CMD_WREN,
    SWP_CMD_WRDI,
    SWP_CMD_PROT,
    SWP_CMD_UNPROT
  } swp_cmd_type;
endpackage

// file: logic/swp_link_if.sv
// Serial link between the host controller and the flash command logic.
`timescale 1ns/1ps
`default_nettype none
interface swp_link_if;
  logic cs_n;
  logic sck;
  logic si;
  modport host (output cs_n, output sck, output si);
  modport dev (input cs_n, input sck, input si);
endinterface
`default_nettype wire

// file: logic/swp_dev.sv
// Flash-side decoder for write enable and sector protection commands.
// Notes on behaviour
// - Program, erase, status write need latch set.
// - Opcode 06h sets latch at deselect.
// - Partial or unaligned write enable is dropped.
// - Opcode 04h clears latch at deselect.
// - Partial or unaligned write disable is dropped.
// - One protect bit per sector, reset to one.
// - Zero permits, one blocks program and erase.
// - 36h plus address protects sector, clears latch.
// - 39h plus address unprotects sector, clears latch.
// - Host sends only the requested opcode; write enable is a separate request.
// - Short sector command: bits kept, latch cleared.
// - Locked: sector commands ignored, latch cleared.
`include "swp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module swp_dev
  import swp_pkg::*;
#(
  parameter int SECTORS = `SWP_SECTORS,
  parameter int SECTOR_LSB = `SWP_SECTOR_LSB
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Serial link.
  swp_link_if.dev link,
  // Lock and requests from the rest of the flash.
  input wire logic protection_regs_lock,
  input wire logic [23:0] op_addr,
  // State seen by the rest of the flash.
  output logic write_enable_latch,
  output logic [SECTORS-1:0] sector_prot,
  output logic op_allowed
);
  localparam int IW = (SECTORS > 1) ? $clog2(SECTORS) : 1;

  // ==========================================================
  // Parameter checks.
  // The sector index is cut straight from the address, so the map must fit in
  // 24 bits and the count must be a power of two, or some indices name no bit.
  if (SECTORS < 1) begin : g_bad_count
    $error("swp_dev: sector count out of range");
  end
  if (SECTOR_LSB < 0) begin : g_bad_lsb
    $error("swp_dev: sector position out of range");
  end
  if ((SECTORS & (SECTORS - 1)) != 0) begin : g_bad_pow2
    $error("swp_dev: sector count must be a power of two");
  end
  if (SECTOR_LSB + $clog2(SECTORS) > 24) begin : g_bad_map
    $error("swp_dev: sector map does not fit a 24-bit address");
  end

  // ==========================================================
  // Input synchronisers and edge detection.
  // Pins are two-stage synchronised; the link clock is slow enough to sample.
  // Data and clock share one pipeline depth, so each bit is read with its edge.
  logic [1:0] cs_s_q, cs_s_d;
  logic [1:0] sck_s_q, sck_s_d;
  logic [1:0] si_s_q, si_s_d;
  logic cs_q, cs_d;
  logic sck_q, sck_d;
  logic cs_low, sck_rise, cs_rise;

  always_comb begin
    cs_s_d = {cs_s_q[0], link.cs_n};
    sck_s_d = {sck_s_q[0], link.sck};
    si_s_d = {si_s_q[0], link.si};
    cs_d = cs_s_q[1];
    sck_d = sck_s_q[1];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_s_q <= 2'h3;
      sck_s_q <= 2'h0;
      si_s_q <= 2'h0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_s_q <= cs_s_d;
      sck_s_q <= sck_s_d;
      si_s_q <= si_s_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
    end
  end

  // Reset levels match the idle pins, so no false edge follows a reset.
  assign cs_low = ~cs_s_q[1];
  assign sck_rise = sck_s_q[1] & ~sck_q & cs_low;
  assign cs_rise = cs_s_q[1] & ~cs_q;

  // ==========================================================
  // Frame shifter: opcode, three address bytes, bit counter.
  logic [7:0] op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [5:0] bits_q, bits_d;
  logic opcode_done, addr_done, aligned;

  assign opcode_done = bits_q >= 6'd8;
  assign addr_done = bits_q >= 6'd32;
  assign aligned = bits_q[2:0] == 3'h0;

  always_comb begin
    op_d = op_q;
    addr_d = addr_q;
    bits_d = bits_q;
    if (sck_rise) begin
      if (!opcode_done) begin
        op_d = {op_q[6:0], si_s_q[1]};
      end else if (!addr_done) begin
        addr_d = {addr_q[22:0], si_s_q[1]};
      end
      // Past the address the count steps back one byte, so trailing bytes are
      // ignored while the bit position within the byte stays true.
      if (bits_q < 6'd40) begin
        bits_d = bits_q + 6'd1;
      end else begin
        bits_d = 6'd33;
      end
    end
    if (cs_rise) begin
      bits_d = 6'd0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      bits_q <= 6'h00;
    end else begin
      op_q <= op_d;
      addr_q <= addr_d;
      bits_q <= bits_d;
    end
  end

  // ==========================================================
  // Command decode at deselect: latch and protection bits.
  logic wel_q, wel_d;
  logic [SECTORS-1:0] prot_q, prot_d;
  logic [IW-1:0] sec_idx;
  logic is_wren, is_wrdi, is_sector, sector_ok;

  assign sec_idx = IW'(addr_q >> SECTOR_LSB);
  assign is_wren = opcode_done && (op_q == `SWP_OP_WREN);
  assign is_wrdi = opcode_done && (op_q == `SWP_OP_WRDI);
  assign is_sector = opcode_done && (op_q == `SWP_OP_PROT || op_q == `SWP_OP_UNPROT);
  // A cut, locked or unlatched sector command still drops the latch below.
  assign sector_ok = wel_q && aligned && addr_done && !protection_regs_lock;

  always_comb begin
    wel_d = wel_q;
    prot_d = prot_q;
    if (cs_rise) begin
      if (is_wren) begin
        if (aligned) begin
          wel_d = 1'b1;
        end
      end else if (is_wrdi) begin
        if (aligned) begin
          wel_d = 1'b0;
        end
      end else if (is_sector) begin
        wel_d = 1'b0;
        // The latch is required; host is expected to set it first.
        if (sector_ok) begin
          prot_d[sec_idx] = (op_q == `SWP_OP_PROT);
        end
      end
    end
    // Unknown opcodes and frames under one byte fall through and change nothing.
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wel_q <= `SWP_WEL_RST;
      prot_q <= {SECTORS{`SWP_PROT_RST}};
    end else begin
      wel_q <= wel_d;
      prot_q <= prot_d;
    end
  end

  // ==========================================================
  // Program and erase gate for the rest of the flash.
  // Registered, so a change of op_addr shows one cycle later.
  logic [IW-1:0] op_idx;
  logic allow_q, allow_d;

  assign op_idx = IW'(op_addr >> SECTOR_LSB);

  always_comb begin
    allow_d = wel_q & ~prot_q[op_idx];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      allow_q <= 1'b0;
    end else begin
      allow_q <= allow_d;
    end
  end

  assign write_enable_latch = wel_q;
  assign sector_prot = prot_q;
  assign op_allowed = allow_q;
endmodule
`default_nettype wire

// file: logic/swp_host.sv
// Host-side sender of write enable and sector protection commands.
`include "swp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module swp_host
  import swp_pkg::*;
#(
  parameter int HALF = `SWP_SCK_HALF
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Serial link.
  swp_link_if.host link,
  // Command request.
  input wire logic req_valid,
  input wire swp_cmd_type req_cmd,
  input wire logic [23:0] req_addr,
  output logic req_ready
);
  // The far end needs at least three of our cycles per half period to see each edge.
  if (HALF < 3 || HALF > 255) begin : g_bad_half
    $error("swp_host: HALF out of range");
  end
  typedef enum logic [1:0] {SWP_H_IDLE, SWP_H_SHIFT, SWP_H_END} swp_hstate_type;

  // ==========================================================
  // Frame sender; the clock is divided down here and driven out.
  swp_hstate_type st_q, st_d;
  logic [31:0] sh_q, sh_d;
  logic [5:0] left_q, left_d;
  logic [7:0] div_q, div_d;
  logic cs_q, cs_d, sck_q, sck_d, rdy_q, rdy_d;
  logic [7:0] op;

  always_comb begin
    case (req_cmd)
      SWP_CMD_WREN: op = `SWP_OP_WREN;
      SWP_CMD_WRDI: op = `SWP_OP_WRDI;
      SWP_CMD_PROT: op = `SWP_OP_PROT;
      default: op = `SWP_OP_UNPROT;
    endcase
  end

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    left_d = left_q;
    div_d = div_q;
    cs_d = cs_q;
    sck_d = sck_q;
    rdy_d = rdy_q;
    case (st_q)
      SWP_H_IDLE: begin
        if (req_valid && rdy_q) begin
          sh_d = {op, req_addr};
          // Only sector commands carry address bytes.
          left_d = (req_cmd == SWP_CMD_PROT || req_cmd == SWP_CMD_UNPROT) ? 6'd32 : 6'd8;
          cs_d = 1'b0;
          rdy_d = 1'b0;
          div_d = 8'h00;
          st_d = SWP_H_SHIFT;
        end
      end
      SWP_H_SHIFT: begin
        if (div_q == 8'(HALF - 1)) begin
          div_d = 8'h00;
          sck_d = ~sck_q;
          if (sck_q) begin
            sh_d = {sh_q[30:0], 1'b0};
            left_d = left_q - 6'd1;
            if (left_q == 6'd1) begin
              st_d = SWP_H_END;
            end
          end
        end else begin
          div_d = div_q + 8'h01;
        end
      end
      SWP_H_END: begin
        if (div_q == 8'(HALF - 1)) begin
          cs_d = 1'b1;
          rdy_d = 1'b1;
          st_d = SWP_H_IDLE;
        end else begin
          div_d = div_q + 8'h01;
        end
      end
      default: st_d = SWP_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= SWP_H_IDLE;
      sh_q <= 32'h00000000;
      left_q <= 6'h00;
      div_q <= 8'h00;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      left_q <= left_d;
      div_q <= div_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
      rdy_q <= rdy_d;
    end
  end
  assign link.cs_n = cs_q;
  assign link.sck = sck_q;
  assign link.si = sh_q[31];
  assign req_ready = rdy_q;
endmodule
`default_nettype wire

// file: bench/swp_checker.sv
// Assertions on the host to flash serial link.
`include "swp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module swp_checker (
  // Link and its clock.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si
);
  logic sck_q, sck_d;
  logic [5:0] n_q, n_d;
  logic [31:0] sr_q, sr_d;
  always_comb begin
    sck_d = sck;
    n_d = cs_n ? 6'h00 : n_q + {5'h00, sck & ~sck_q};
    sr_d = (sck & ~sck_q) ? {sr_q[30:0], si} : sr_q;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      n_q <= 6'h00;
      sr_q <= 32'h00000000;
    end else begin
      sck_q <= sck_d;
      n_q <= n_d;
      sr_q <= sr_d;
    end
  end
  // ==========
  // Properties; one clock serves both ends, so defaults are set once.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_low3; !sck [*3]; endsequence
  property p_idle; cs_n |-> !sck; endproperty
  a_idle: assert property (p_idle) else $error("sck moves while deselected");
  property p_hold; $changed(si) |-> !sck; endproperty
  a_hold: assert property (p_hold) else $error("si changes while sck high");
  property p_high; $rose(sck) |=> sck [*3]; endproperty
  a_high: assert property (p_high) else $error("sck high phase short");
  property p_low; $fell(sck) |=> s_low3; endproperty
  a_low: assert property (p_low) else $error("sck low phase short");
  property p_start; $fell(cs_n) |-> s_low3; endproperty
  a_start: assert property (p_start) else $error("sck rises too soon");
  property p_len; $rose(cs_n) |-> n_q == 6'h08 || n_q == 6'h20; endproperty
  a_len: assert property (p_len) else $error("frame not whole bytes");
  property p_short; $rose(cs_n) && n_q == 6'h08 |-> sr_q[7:0] inside {`SWP_OP_WREN, `SWP_OP_WRDI};
  endproperty
  a_short: assert property (p_short) else $error("bad short opcode");
  property p_long; $rose(cs_n) && n_q == 6'h20 |-> sr_q[31:24] inside {`SWP_OP_PROT, `SWP_OP_UNPROT};
  endproperty
  a_long: assert property (p_long) else $error("bad sector opcode");
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the write-protect link.
`include "swp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb
  import swp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic lock = 1'b0;
  logic req_valid = 1'b0;
  swp_cmd_type req_cmd = SWP_CMD_WREN;
  logic [23:0] req_addr = 24'h000000;
  logic [23:0] op_addr = 24'h000000;
  logic req_ready, wel1, ok1, wel2, ok2;
  logic [7:0] prot1, prot2;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 32'hbf9623ca;
  logic m_wel [2];
  logic [7:0] m_prot [2];
  logic [7:0] ops [4] = '{`SWP_OP_WREN, `SWP_OP_WRDI, `SWP_OP_PROT, `SWP_OP_UNPROT};
  swp_link_if lk ();
  swp_link_if lk2 ();
  always #50 clk_sys = ~clk_sys;
  swp_host swp_host_i (.clk_sys(clk_sys), .rst(rst), .link(lk.host), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_ready(req_ready));
  swp_dev swp_dev_i (.clk_sys(clk_sys), .rst(rst), .link(lk.dev), .protection_regs_lock(lock),
    .op_addr(op_addr), .write_enable_latch(wel1), .sector_prot(prot1), .op_allowed(ok1));
  // The second device hears a bench driver that may cut frames short.
  swp_dev swp_dev_fault_i (.clk_sys(clk_sys), .rst(rst), .link(lk2.dev),
    .protection_regs_lock(lock), .op_addr(op_addr), .write_enable_latch(wel2),
    .sector_prot(prot2), .op_allowed(ok2));
  swp_checker swp_checker_i (.clk_sys(clk_sys), .rst(rst), .cs_n(lk.cs_n), .sck(lk.sck),
    .si(lk.si));
  // ==========
  // Tasks.
  task automatic check(string nm, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic judge(int k, logic [31:0] w, int n);
    repeat (8) @(negedge clk_sys);
    if (n >= 8 && n % 8 == 0 && w[31:24] == `SWP_OP_WREN) m_wel[k] = 1'b1;
    if (n >= 8 && n % 8 == 0 && w[31:24] == `SWP_OP_WRDI) m_wel[k] = 1'b0;
    if (n >= 8 && w[31:24] inside {`SWP_OP_PROT, `SWP_OP_UNPROT}) begin
      if (n % 8 == 0 && n >= 32 && m_wel[k] && !lock)
        m_prot[k][w[18:16]] = w[31:24] == `SWP_OP_PROT;
      m_wel[k] = 1'b0;
    end
    check("latch", 8'(k ? wel2 : wel1), 8'(m_wel[k]));
    check("prot", k ? prot2 : prot1, m_prot[k]);
    check("allowed", 8'(k ? ok2 : ok1), 8'(m_wel[k] & ~m_prot[k][op_addr[18:16]]));
  endtask
  task automatic send(swp_cmd_type c, logic [23:0] a);
    int t;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    t = 0;
    repeat (2) @(negedge clk_sys);
    while (req_ready !== 1'b1 && t < 1000) begin
      @(negedge clk_sys);
      t++;
    end
    check("ready", 8'(req_ready), 8'h01);
    judge(0, {ops[c], a}, c < 2 ? 8 : 32);
  endtask
  // Bits go out MSB first; the released data line shows the inverse level.
  task automatic raw(logic [31:0] w, int n);
    logic [31:0] s;
    s = w;
    @(posedge clk_sys);
    lk2.cs_n <= 1'b0;
    lk2.si <= s[31];
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys);
      lk2.sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      lk2.sck <= 1'b0;
      s = s << 1;
      lk2.si <= s[31];
    end
    repeat (4) @(posedge clk_sys);
    lk2.cs_n <= 1'b1;
    lk2.si <= ~s[31];
    judge(1, w, n);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    m_wel = '{1'b0, 1'b0};
    m_prot = '{8'hFF, 8'hFF};
    judge(0, 32'h00000000, 0);
    judge(1, 32'h00000000, 0);
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 50000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    lk2.cs_n = 1'b1;
    lk2.sck = 1'b0;
    lk2.si = 1'b0;
    do_reset();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      lock <= ($random(seed) & 3) == 0;
      op_addr <= 24'($random(seed));
      send(SWP_CMD_WREN, 24'h000000);
      send(swp_cmd_type'(2'($random(seed))), 24'($random(seed)));
    end
    $display("test host link done");
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_sys);
      lock <= ($random(seed) & 3) == 0;
      raw({ops[0], 24'h000000}, 8);
      raw({ops[$random(seed) & 3], 24'($random(seed))}, 1 + ($random(seed) & 63));
    end
    $display("test cut frames done");
    do_reset();
    $display("test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
